// >>> pkg/fsl_defs.svh
// Constants for the flash secure-region, parameter-table and lock command logic
`ifndef FSL_DEFS_SVH
`define FSL_DEFS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FSL_OP_PTAB 8'h5a
`define FSL_OP_SERASE 8'h44
`define FSL_OP_SPROG 8'h42
`define FSL_OP_SREAD 8'h48
`define FSL_OP_LOCK 8'h36
`define FSL_OP_UNLOCK 8'h39

// ----------------------------------------------------------------
// Frame bit counts (rising edges seen before the current one)
// ----------------------------------------------------------------
`define FSL_CNT_OPC 6'h07
`define FSL_CNT_ADDR 6'h1f
`define FSL_CNT_DATA 6'h20
`define FSL_CNT_READ 6'h28

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define FSL_RGN_HI_MSB 23
`define FSL_RGN_HI_LSB 16
`define FSL_RGN_SEL_MSB 15
`define FSL_RGN_SEL_LSB 12
`define FSL_RGN_PAD_MSB 11
`define FSL_RGN_PAD_LSB 8
`define FSL_RGN_IDX_MSB 13
`define FSL_RGN_IDX_LSB 12
`define FSL_BLK_MSB 20
`define FSL_BLK_LSB 16
`define FSL_RGN1 4'h1
`define FSL_RGN2 4'h2
`define FSL_RGN3 4'h3

// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define FSL_ERASED_BYTE 8'hff
`define FSL_LOCKS_RST 32'hffff_ffff
`define FSL_CLK_MHZ 20
`define FSL_ERASE_TIME_US 1000
`define FSL_PROG_TIME_US 400

`endif

// >>> pkg/fsl_pkg.sv
// Types for the flash secure-region, parameter-table and lock command logic
`default_nettype none
package fsl_pkg;

  // ----------------------------------------------------------------
  // Command in the current frame
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CMD_IDLE = 8'h01,
    CMD_PTAB = 8'h02,
    CMD_SREAD = 8'h04,
    CMD_SERASE = 8'h08,
    CMD_SPROG = 8'h10,
    CMD_LOCK = 8'h20,
    CMD_UNLOCK = 8'h40,
    CMD_NONE = 8'h80
  } fsl_cmd_e;

  // ----------------------------------------------------------------
  // Self-timed operation
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE = 3'h1,
    OP_FILL = 3'h2,
    OP_WAIT = 3'h4
  } fsl_op_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic serial_in_line;
  } fsl_spi_in_s;

  typedef struct packed {
    logic en;
    logic [9:0] addr;
    logic [7:0] data;
  } fsl_mem_wr_s;

endpackage : fsl_pkg
`default_nettype wire

// >>> logic/fsl_mem.sv
// Byte memory with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module fsl_mem #(
  parameter int unsigned AW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule : fsl_mem
`default_nettype wire

// >>> logic/fsl_cmd_core.sv
// Serial flash command logic: parameter table, security regions, block locks
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defs.svh"

// Function
// RULE1 - Opcode 5Ah, address, eight dummies; table bytes leave MSB first from clock 40
// RULE2 - Table holds 256 bytes; low address byte is the start offset
// RULE3 - Three regions picked by A15-12 of 1,2,3 with A23-16 and A11-8 zero
// RULE4 - Opcode 44h erases the addressed region only when the write latch is set
// RULE5 - Erase runs only if select rises right after the last address bit
// RULE6 - Busy stays high for the whole self-timed erase, status stays readable
// RULE7 - Finished region erase clears the write latch
// RULE8 - A region with its one-time lock set ignores erase
// RULE9 - A region with its one-time lock set ignores program
// RULE10 - Opcode 42h programs 1 to 256 bytes into erased bytes, latch required
// RULE11 - Host keeps select low and sends at least one data byte when programming
// RULE12 - Opcode 48h, address, eight dummies; data leaves on falling edges MSB first
// RULE13 - Region read offset increments per byte and wraps FFh to 00h
// RULE14 - Region read while busy is ignored, running cycle untouched
// RULE15 - Block locks apply only with scheme select 1, else legacy protect fields
// RULE16 - Block lock bits are volatile and all set to 1 after reset
// RULE17 - Opcode 36h plus address locks one block, latch required
// RULE18 - Opcode 39h plus address unlocks one block, latch required
// RULE19 - Latch-gated command without the latch changes nothing
module fsl_cmd_core #(
  parameter int unsigned ERASE_CYCLES = `FSL_ERASE_TIME_US * `FSL_CLK_MHZ,
  parameter int unsigned PROG_CYCLES = `FSL_PROG_TIME_US * `FSL_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fsl_pkg::fsl_spi_in_s spi_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic write_latch_flag,
  output logic write_latch_clear,
  input wire logic busy_ext,
  output logic busy_flag,
  input wire logic [2:0] otp_region_locks,
  input wire logic protect_scheme_select,
  input wire logic [31:0] legacy_protect_mask,
  output logic [31:0] array_protect_mask,
  output logic [31:0] block_lock_bits,
  input wire fsl_pkg::fsl_mem_wr_s ptab_load
);

  // ----------------------------------------------------------------
  // Frame edges
  // ----------------------------------------------------------------
  logic cs_prev_r;
  logic sclk_prev_r;
  wire logic frame = ~spi_in.cs_n;
  wire logic sclk_rise = frame & spi_in.sclk & ~sclk_prev_r;
  wire logic sclk_fall = frame & ~spi_in.sclk & sclk_prev_r;
  wire logic cs_rise = spi_in.cs_n & ~cs_prev_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
    end else begin
      cs_prev_r <= spi_in.cs_n;
      sclk_prev_r <= spi_in.sclk;
    end
  end

  // ----------------------------------------------------------------
  // Bit counting and input shift
  // ----------------------------------------------------------------
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [2:0] ph_r;
  logic [30:0] sr_r;

  wire logic [7:0] in_byte = {sr_r[6:0], spi_in.serial_in_line};
  wire logic [23:0] in_addr = {sr_r[22:0], spi_in.serial_in_line};
  wire logic at_opc = sclk_rise & (cnt_r == `FSL_CNT_OPC);
  wire logic at_addr = sclk_rise & (cnt_r == `FSL_CNT_ADDR);
  wire logic past_addr = cnt_r >= `FSL_CNT_DATA;
  wire logic data_byte_done = sclk_rise & past_addr & (ph_r == 3'h7);

  // Saturates at the read start so reads may run on without limit
  assign cnt_nxt = !frame ? 6'h00 :
                   (sclk_rise && cnt_r != `FSL_CNT_READ) ? cnt_r + 6'h01 : cnt_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
      ph_r <= 3'h0;
      sr_r <= 31'h0000_0000;
    end else begin
      cnt_r <= cnt_nxt;
      ph_r <= !frame ? 3'h0 : (sclk_rise ? ph_r + 3'h1 : ph_r);
      if (sclk_rise) begin
        sr_r <= {sr_r[29:0], spi_in.serial_in_line};
      end
    end
  end

  // ----------------------------------------------------------------
  // Address checks
  // ----------------------------------------------------------------
  wire logic [3:0] rgn_sel = in_addr[`FSL_RGN_SEL_MSB:`FSL_RGN_SEL_LSB];
  wire logic rgn_hi_zero = in_addr[`FSL_RGN_HI_MSB:`FSL_RGN_HI_LSB] == 8'h00;
  wire logic rgn_pad_zero = in_addr[`FSL_RGN_PAD_MSB:`FSL_RGN_PAD_LSB] == 4'h0;
  wire logic [2:0] rgn_onehot = {rgn_sel == `FSL_RGN3, rgn_sel == `FSL_RGN2, rgn_sel == `FSL_RGN1};
  wire logic rgn_ok = rgn_hi_zero & rgn_pad_zero & (|rgn_onehot); // RULE3
  wire logic rgn_locked = |(rgn_onehot & otp_region_locks); // RULE8 RULE9

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  fsl_pkg::fsl_cmd_e cmd_r;
  fsl_pkg::fsl_cmd_e cmd_nxt;
  fsl_pkg::fsl_cmd_e opc_cmd;
  fsl_pkg::fsl_cmd_e addr_cmd;
  fsl_pkg::fsl_op_e op_r;
  wire logic busy_any = busy_flag | busy_ext;
  wire logic short_cmd = (cmd_r == fsl_pkg::CMD_SERASE) | (cmd_r == fsl_pkg::CMD_LOCK) |
                         (cmd_r == fsl_pkg::CMD_UNLOCK);

  always_comb begin
    opc_cmd = fsl_pkg::CMD_NONE;
    case (in_byte)
      `FSL_OP_PTAB: opc_cmd = fsl_pkg::CMD_PTAB; // RULE1
      `FSL_OP_SREAD: opc_cmd = busy_any ? fsl_pkg::CMD_NONE : fsl_pkg::CMD_SREAD; // RULE14
      `FSL_OP_SERASE: opc_cmd = busy_any ? fsl_pkg::CMD_NONE : fsl_pkg::CMD_SERASE;
      `FSL_OP_SPROG: opc_cmd = busy_any ? fsl_pkg::CMD_NONE : fsl_pkg::CMD_SPROG;
      `FSL_OP_LOCK: opc_cmd = busy_any ? fsl_pkg::CMD_NONE : fsl_pkg::CMD_LOCK;
      `FSL_OP_UNLOCK: opc_cmd = busy_any ? fsl_pkg::CMD_NONE : fsl_pkg::CMD_UNLOCK;
      default: opc_cmd = fsl_pkg::CMD_NONE;
    endcase
  end

  // Latch and lock checks drop the command before anything is touched
  always_comb begin
    addr_cmd = cmd_r;
    unique case (cmd_r)
      fsl_pkg::CMD_SREAD: if (!rgn_ok) addr_cmd = fsl_pkg::CMD_NONE; // RULE3
      fsl_pkg::CMD_SERASE: if (!rgn_ok || !write_latch_flag || rgn_locked) addr_cmd = fsl_pkg::CMD_NONE; // RULE4 RULE8 RULE19
      fsl_pkg::CMD_SPROG: if (!rgn_ok || !write_latch_flag || rgn_locked) addr_cmd = fsl_pkg::CMD_NONE; // RULE9 RULE10 RULE19
      fsl_pkg::CMD_LOCK: if (!write_latch_flag) addr_cmd = fsl_pkg::CMD_NONE; // RULE17 RULE19
      fsl_pkg::CMD_UNLOCK: if (!write_latch_flag) addr_cmd = fsl_pkg::CMD_NONE; // RULE18 RULE19
      fsl_pkg::CMD_IDLE, fsl_pkg::CMD_PTAB, fsl_pkg::CMD_NONE: addr_cmd = cmd_r;
      default: addr_cmd = fsl_pkg::CMD_NONE;
    endcase
  end

  always_comb begin
    cmd_nxt = cmd_r;
    if (!frame) begin
      cmd_nxt = fsl_pkg::CMD_IDLE;
    end else if (at_opc) begin
      cmd_nxt = opc_cmd;
    end else if (at_addr) begin
      cmd_nxt = addr_cmd;
    end else if (sclk_rise && past_addr && short_cmd) begin
      cmd_nxt = fsl_pkg::CMD_NONE; // RULE5
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= fsl_pkg::CMD_IDLE;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Address latch and byte pointer
  // ----------------------------------------------------------------
  logic [23:0] addr_r;
  logic [7:0] ptr_r;
  logic [7:0] pbyte_r;
  logic pend_r;
  logic prog_seen_r;
  logic [7:0] ptab_rd;
  logic [7:0] sec_rd;

  wire logic is_read = (cmd_r == fsl_pkg::CMD_PTAB) | (cmd_r == fsl_pkg::CMD_SREAD);
  wire logic rd_slot = sclk_fall & is_read & (cnt_r == `FSL_CNT_READ);
  wire logic rd_load = rd_slot & (ph_r == 3'h0); // RULE1 RULE12
  wire logic rd_shift = rd_slot & (ph_r != 3'h0);
  wire logic prog_byte = data_byte_done & (cmd_r == fsl_pkg::CMD_SPROG);
  wire logic [1:0] rgn_idx = addr_r[`FSL_RGN_IDX_MSB:`FSL_RGN_IDX_LSB];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 24'h00_0000;
      ptr_r <= 8'h00;
      pbyte_r <= 8'h00;
      pend_r <= 1'b0;
      prog_seen_r <= 1'b0;
    end else begin
      if (at_addr) begin
        addr_r <= in_addr;
        ptr_r <= in_addr[7:0]; // RULE2
      end else if (rd_load || pend_r) begin
        ptr_r <= ptr_r + 8'h01; // RULE13
      end
      pend_r <= prog_byte;
      if (prog_byte) begin
        pbyte_r <= in_byte;
      end
      if (cmd_r == fsl_pkg::CMD_IDLE) begin
        prog_seen_r <= 1'b0;
      end else if (prog_byte) begin
        prog_seen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic [7:0] out_sr_r;
  logic out_en_r;
  wire logic [7:0] rd_byte = (cmd_r == fsl_pkg::CMD_PTAB) ? ptab_rd : sec_rd;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sr_r <= 8'h00;
      out_en_r <= 1'b0;
    end else begin
      if (!frame) begin
        out_en_r <= 1'b0;
      end else if (rd_load) begin
        out_en_r <= 1'b1;
      end
      if (rd_load) begin
        out_sr_r <= rd_byte; // RULE1 RULE12
      end else if (rd_shift) begin
        out_sr_r <= {out_sr_r[6:0], 1'b0};
      end
    end
  end

  assign serial_out = out_sr_r[7];
  assign serial_out_en = out_en_r;

  // ----------------------------------------------------------------
  // Self-timed erase and program
  // ----------------------------------------------------------------
  logic [23:0] tmr_r;
  logic [7:0] fill_r;
  logic [1:0] erase_rgn_r;
  logic wel_clr_r;
  wire logic exec_slot = cs_rise & (cnt_r == `FSL_CNT_DATA);
  wire logic erase_go = exec_slot & (cmd_r == fsl_pkg::CMD_SERASE); // RULE5
  wire logic prog_go = cs_rise & (cmd_r == fsl_pkg::CMD_SPROG) & prog_seen_r; // RULE10
  wire logic lock_go = exec_slot & (cmd_r == fsl_pkg::CMD_LOCK);
  wire logic unlock_go = exec_slot & (cmd_r == fsl_pkg::CMD_UNLOCK);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= fsl_pkg::OP_IDLE;
      tmr_r <= 24'h00_0000;
      fill_r <= 8'h00;
      erase_rgn_r <= 2'h0;
      wel_clr_r <= 1'b0;
    end else begin
      wel_clr_r <= 1'b0;
      unique case (op_r)
        fsl_pkg::OP_IDLE: begin
          if (erase_go) begin
            op_r <= fsl_pkg::OP_FILL; // RULE6
            fill_r <= 8'h00;
            erase_rgn_r <= rgn_idx;
          end else if (prog_go) begin
            op_r <= fsl_pkg::OP_WAIT;
            tmr_r <= 24'(PROG_CYCLES - 1);
          end
        end
        fsl_pkg::OP_FILL: begin
          fill_r <= fill_r + 8'h01;
          if (fill_r == 8'hff) begin
            op_r <= fsl_pkg::OP_WAIT;
            tmr_r <= 24'(ERASE_CYCLES - 1);
          end
        end
        fsl_pkg::OP_WAIT: begin
          tmr_r <= tmr_r - 24'h00_0001;
          if (tmr_r == 24'h00_0000) begin
            op_r <= fsl_pkg::OP_IDLE; // RULE6
            wel_clr_r <= 1'b1; // RULE7
          end
        end
        default: op_r <= fsl_pkg::OP_IDLE;
      endcase
    end
  end

  assign busy_flag = op_r != fsl_pkg::OP_IDLE; // RULE6
  assign write_latch_clear = wel_clr_r;

  // ----------------------------------------------------------------
  // Security memory ports
  // ----------------------------------------------------------------
  wire logic filling = op_r == fsl_pkg::OP_FILL;
  wire logic sec_wr_en = filling | pend_r;
  wire logic [9:0] sec_wr_addr = filling ? {erase_rgn_r, fill_r} : {rgn_idx, ptr_r};
  // Program only clears bits, so an unerased byte keeps its zeros
  wire logic [7:0] sec_wr_data = filling ? `FSL_ERASED_BYTE : (pbyte_r & sec_rd); // RULE10
  wire logic [9:0] sec_rd_addr = {rgn_idx, ptr_r};

  fsl_mem #(
    .AW(10)
  ) u_sec_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(sec_wr_en),
    .wr_addr(sec_wr_addr),
    .wr_data(sec_wr_data),
    .rd_addr(sec_rd_addr),
    .rd_data(sec_rd)
  );

  fsl_mem #(
    .AW(8)
  ) u_ptab_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(ptab_load.en),
    .wr_addr(ptab_load.addr[7:0]),
    .wr_data(ptab_load.data),
    .rd_addr(ptr_r),
    .rd_data(ptab_rd)
  );

  // ----------------------------------------------------------------
  // Block locks
  // ----------------------------------------------------------------
  logic [31:0] locks_r;
  logic [31:0] prot_r;
  wire logic [4:0] blk_idx = addr_r[`FSL_BLK_MSB:`FSL_BLK_LSB];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      locks_r <= `FSL_LOCKS_RST; // RULE16
      prot_r <= `FSL_LOCKS_RST;
    end else begin
      if (lock_go) begin
        locks_r[blk_idx] <= 1'b1; // RULE17
      end else if (unlock_go) begin
        locks_r[blk_idx] <= 1'b0; // RULE18
      end
      prot_r <= protect_scheme_select ? locks_r : legacy_protect_mask; // RULE15
    end
  end

  assign block_lock_bits = locks_r;
  assign array_protect_mask = prot_r;

endmodule : fsl_cmd_core
`default_nettype wire

// >>> dv/fsl_cmd_chk.sv
// Port checker for the flash command block
`timescale 1ns/10ps
`default_nettype none
module fsl_cmd_chk #(
  parameter int unsigned ERASE_CYCLES = 4,
  parameter int unsigned PROG_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fsl_pkg::fsl_spi_in_s spi_in,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic write_latch_flag,
  input wire logic write_latch_clear,
  input wire logic busy_ext,
  input wire logic busy_flag,
  input wire logic protect_scheme_select,
  input wire logic [31:0] legacy_protect_mask,
  input wire logic [31:0] array_protect_mask,
  input wire logic [31:0] block_lock_bits
);
  // ----------------------------------------------------------------
  // Busy length counter and properties
  // ----------------------------------------------------------------
  localparam int BUSY_MAX = ERASE_CYCLES + PROG_CYCLES + 600;
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  assign busy_cnt_nxt = busy_flag ? busy_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= busy_cnt_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  lock_reset_a: assert property ($rose(rst_n) |-> block_lock_bits == 32'hffff_ffff)
    else $error("lock bits not all set after reset");
  mask_follow_a: assert property (1'b1 |=> array_protect_mask == ($past(protect_scheme_select) ?
    $past(block_lock_bits) : $past(legacy_protect_mask))) else $error("protect mask wrong source");
  lock_change_a: assert property (!$stable(block_lock_bits) |-> spi_in.cs_n && write_latch_flag &&
    $countones(block_lock_bits ^ $past(block_lock_bits)) == 1) else $error("lock bits changed wrongly");
  busy_gate_a: assert property ($rose(busy_flag) |-> spi_in.cs_n && write_latch_flag && !busy_ext)
    else $error("busy started without cause");
  latch_clr_a: assert property (write_latch_clear |-> $fell(busy_flag) ##1 !write_latch_clear)
    else $error("latch clear pulse misplaced");
  clr_done_a: assert property ($fell(busy_flag) |-> write_latch_clear)
    else $error("no latch clear at end of cycle");
  busy_min_a: assert property ($rose(busy_flag) |-> busy_flag [*3])
    else $error("busy dropped too early");
  busy_len_a: assert property (busy_cnt_r <= 32'(BUSY_MAX))
    else $error("busy held too long");
  out_quiet_a: assert property (spi_in.cs_n [*3] |-> !serial_out_en)
    else $error("output driven outside frame");
  read_idle_a: assert property ($rose(serial_out_en) |-> !busy_flag && !busy_ext)
    else $error("read served while busy");
  out_hold_a: assert property (serial_out_en && !spi_in.cs_n && spi_in.sclk && $past(spi_in.sclk) |=>
    $stable(serial_out)) else $error("output moved without clock fall");
  read_c: cover property ($rose(serial_out_en));
  busy_c: cover property ($fell(busy_flag));
  lock_c: cover property (!$stable(block_lock_bits));
endmodule : fsl_cmd_chk

bind fsl_cmd_core fsl_cmd_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .spi_in(spi_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
  .write_latch_flag(write_latch_flag), .write_latch_clear(write_latch_clear), .busy_ext(busy_ext),
  .busy_flag(busy_flag), .protect_scheme_select(protect_scheme_select),
  .legacy_protect_mask(legacy_protect_mask), .array_protect_mask(array_protect_mask),
  .block_lock_bits(block_lock_bits)
);
`default_nettype wire

// >>> dv/fsl_host_model.sv
// Serial host model driving command frames
`timescale 1ns/10ps
`default_nettype none
module fsl_host_model (
  input wire logic ref_clk,
  output var fsl_pkg::fsl_spi_in_s spi,
  input wire logic serial_out,
  input wire logic serial_out_en,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic en_seen
);
  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  logic tx_bits [$];
  logic [7:0] sh;
  initial begin
    spi = 3'b100;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    en_seen = 1'b0;
  end
  // Released data line toggles
  always @(negedge ref_clk) begin
    if (spi.cs_n) spi.serial_in_line <= ~spi.serial_in_line;
  end
  task automatic run(input int nrd);
    int n;
    n = tx_bits.size();
    repeat (3) @(negedge ref_clk);
    spi.sclk = 1'b0;
    en_seen = 1'b0;
    spi.cs_n = 1'b0;
    for (int i = 0; i < n + 8 * nrd; i++) begin
      @(negedge ref_clk);
      rx_valid = 1'b0;
      spi.sclk = 1'b0;
      if (i < n) spi.serial_in_line = tx_bits.pop_front();
      repeat (2) @(negedge ref_clk);
      if (i >= n) begin
        en_seen = en_seen | serial_out_en;
        sh = {sh[6:0], serial_out};
        if ((i - n) % 8 == 7 && serial_out_en) begin
          rx_byte = sh;
          rx_valid = 1'b1;
        end
      end
      spi.sclk = 1'b1;
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    spi.cs_n = 1'b1;
  endtask : run
endmodule : fsl_host_model
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the flash command block
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Signals, design and host
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n, write_latch_flag, busy_ext, protect_scheme_select;
  logic [2:0] otp_region_locks;
  logic [31:0] legacy_protect_mask;
  fsl_pkg::fsl_mem_wr_s ptab_load;
  fsl_pkg::fsl_spi_in_s spi_in;
  logic serial_out, serial_out_en, write_latch_clear, busy_flag, rx_valid, en_seen;
  logic [31:0] array_protect_mask, block_lock_bits, lk;
  logic [31:0] seed = 32'hcd8897fb;
  logic [7:0] rx_byte;
  logic [4:0] blk;
  logic [7:0] tab [256];
  logic [7:0] dat [4];
  logic [7:0] expq [$];
  int errors = 0, comparisons = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  fsl_cmd_core #(.ERASE_CYCLES(200), .PROG_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .spi_in(spi_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .write_latch_flag(write_latch_flag),
    .write_latch_clear(write_latch_clear), .busy_ext(busy_ext), .busy_flag(busy_flag),
    .otp_region_locks(otp_region_locks), .protect_scheme_select(protect_scheme_select),
    .legacy_protect_mask(legacy_protect_mask), .array_protect_mask(array_protect_mask),
    .block_lock_bits(block_lock_bits), .ptab_load(ptab_load));
  fsl_host_model host (.ref_clk(ref_clk), .spi(spi_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .en_seen(en_seen));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [23:0] ra(input int g, input logic [7:0] o);
    return {8'h00, 4'(g), 4'h0, o};
  endfunction : ra
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) host.tx_bits.push_back(v[i]);
  endtask : put
  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int nad, input int ndum);
    put(op, 8);
    put(a >> (24 - nad), nad);
    put(32'h0, ndum);
  endtask : hdr
  task automatic wait_busy(input logic e);
    logic b, c;
    b = 1'b0;
    c = 1'b0;
    for (int i = 0; i < 1500; i++) begin
      @(negedge ref_clk);
      b = b | busy_flag;
      c = c | write_latch_clear;
      if (b && !busy_flag) break;
    end
    chk(b, e, "busy");
    chk(c, e, "latch clear");
  endtask : wait_busy
  always @(posedge rx_valid) begin
    if (expq.size() == 0) chk(1'b1, 1'b0, "extra byte");
    else chk(rx_byte, expq.pop_front(), "read byte");
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {write_latch_flag, busy_ext, protect_scheme_select, otp_region_locks} = 6'h00;
    ptab_load = '0;
    legacy_protect_mask = rnd();
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(block_lock_bits, 32'hffff_ffff, "lock reset");
    chk(array_protect_mask, legacy_protect_mask, "legacy mask");
    for (int i = 0; i < 256; i++) begin
      tab[i] = 8'(rnd());
      ptab_load = {1'b1, 10'(i), tab[i]};
      @(negedge ref_clk);
    end
    ptab_load = '0;
    expq = {tab[254], tab[255], tab[0]};
    hdr(8'h5a, 24'h0000fe, 24, 8);
    host.run(3);
    for (int g = 1; g <= 3; g++) begin
      write_latch_flag = 1'b1;
      hdr(8'h44, ra(g, 8'h5c), 24, 0);
      host.run(0);
      wait_busy(1'b1);
      dat[g] = 8'(rnd());
      hdr(8'h42, ra(g, 8'hff), 24, 0);
      put(dat[g], 8);
      put(~dat[g], 8);
      host.run(0);
      wait_busy(1'b1);
      expq = {8'hff, dat[g], ~dat[g]};
      hdr(8'h48, ra(g, 8'hfe), 24, 8);
      host.run(3);
    end
    for (int t = 0; t < 6; t++) begin
      write_latch_flag = (t > 1);
      otp_region_locks = (t == 3 || t == 4) ? 3'h1 : 3'h0;
      if (t == 0 || t == 4) begin
        hdr(8'h42, ra(1, 8'h01), 24, 0);
        put(32'h0, 8);
      end else begin
        hdr(8'h44, ra(1, 8'h00), (t == 2) ? 23 : 24, 0);
        if (t == 5) put(32'h0, 1);
      end
      host.run(0);
      wait_busy(1'b0);
    end
    otp_region_locks = 3'h0;
    expq = {dat[1], ~dat[1], 8'hff};
    hdr(8'h48, ra(1, 8'hff), 24, 8);
    host.run(3);
    for (int t = 0; t < 3; t++) begin
      busy_ext = (t == 0);
      if (t == 2) begin
        hdr(8'h44, ra(3, 8'h00), 24, 0);
        host.run(0);
      end
      hdr(8'h48, (t == 1) ? 24'h001100 : ra(1, 8'h00), 24, 8);
      host.run(1);
      chk(en_seen, 1'b0, "refused read");
      if (t == 2) wait_busy(1'b1);
    end
    busy_ext = 1'b0;
    protect_scheme_select = 1'b1;
    lk = 32'hffff_ffff;
    for (int t = 0; t < 9; t++) begin
      if (t % 3 == 0) blk = (t == 0) ? 5'd0 : (t == 3) ? 5'd31 : 5'(rnd());
      write_latch_flag = (t % 3 != 1);
      hdr((t % 3 == 0) ? 8'h39 : 8'h36, {3'h0, blk, 16'(rnd())}, 24, 0);
      host.run(0);
      repeat (4) @(negedge ref_clk);
      if (write_latch_flag) lk[blk] = (t % 3 != 0);
      chk(block_lock_bits, lk, "lock bits");
      chk(array_protect_mask, lk, "lock mask");
    end
    hdr(8'h39, 24'h070000, 24, 0);
    host.run(0);
    repeat (4) @(negedge ref_clk);
    chk(block_lock_bits[7], 1'b0, "unlocked");
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(block_lock_bits, 32'hffff_ffff, "lock reset");
    protect_scheme_select = 1'b0;
    legacy_protect_mask = rnd();
    repeat (2) @(negedge ref_clk);
    chk(array_protect_mask, legacy_protect_mask, "legacy mask");
    chk(32'(expq.size()), 32'h0, "missing bytes");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
